// ==== radio_cfg.svh ====
// constants for the radio strobe and interrupt block
// Notes on behaviour
// - strobe 00 turns synthesizer on, maybe calibrates
// - strobe 01 calibrates then switches synthesizer off
// - strobe 02 enters receive, calibrating from idle
// - strobe 03 transmits; from receive only if clear when cca_enable is set
// - strobe 04 goes idle; others do nothing
// - five strobes, each starts its own sequence
// - idle strobe drops others until idle reached
// - two interrupt vectors: data transfer, events
// - event flags set on rising status edges
// - data flag when byte ready or room
// - no transmit data flag before transmit strobe
// - data request needs flag and enable
// - status byte 1 read re-arms data flag when status_append_enable is set
// - eight event sources feed event interrupt
// - event flag set regardless of mask
// - masked event also sets cpu flag
// - event request needs cpu flag and enable
// - event flag bit layout, reset 0, write-0 clears
// - unread received byte overrun sets overflow, done
// - overflow or underflow left only by idle strobe
`ifndef RADIO_CFG_SVH
`define RADIO_CFG_SVH
`define STROBE_SYNTH_ON 8'h00
`define STROBE_CALIBRATE 8'h01
`define STROBE_RECEIVE 8'h02
`define STROBE_TRANSMIT 8'h03
`define STROBE_IDLE 8'h04
`define AUTOCAL_FROM_IDLE 2'h1
`define EV_TX_UNDERFLOW 7
`define EV_RX_OVERFLOW 6
`define EV_TIMEOUT 5
`define EV_DONE 4
`define EV_CARRIER 3
`define EV_PREAMBLE 2
`define EV_CLEAR_CH 1
`define EV_FRAME_START 0
`define EVENT_FLAGS_RESET 8'h00
`define CAL_TIME_NS 800
`define CAL_CYCLES ((`CAL_TIME_NS + 7) / 8)
`define SETTLE_TIME_NS 80
`define SETTLE_CYCLES ((`SETTLE_TIME_NS + 7) / 8)
`endif

// ==== radio_pkg.sv ====
// types for the radio strobe and interrupt block
package radio_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CAL = 3'b001,
        ST_SYNTH = 3'b010,
        ST_RX = 3'b011,
        ST_TX = 3'b100,
        ST_LEAVE = 3'b101,
        ST_RX_OVF = 3'b110,
        ST_TX_UNF = 3'b111
    } radio_state_t;
    typedef enum logic [1:0] {
        AFTER_IDLE = 2'b00,
        AFTER_SYNTH = 2'b01,
        AFTER_RX = 2'b10,
        AFTER_TX = 2'b11
    } cal_target_t;
    typedef struct packed {
        logic write;
        logic [7:0] value;
    } strobe_req_t;
    typedef struct packed {
        logic tx_underflow;
        logic rx_overflow;
        logic timeout;
        logic done;
        logic carrier;
        logic preamble;
        logic clear_channel;
        logic frame_start;
    } event_vec_t;
endpackage

// ==== radio_strobe_and_interrupts.sv ====
// strobe sequencer and interrupt flags for the sub-GHz radio
`timescale 1ns/1ps
`include "radio_cfg.svh"
module radio_strobe_and_interrupts #(
    parameter int CAL_CYCLES = `CAL_CYCLES,
    parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // command strobe writes to radio_command_register
    input wire radio_pkg::strobe_req_t strobe,
    // configuration
    input wire logic [1:0] auto_calibration_select,
    input wire logic cca_enable,
    input wire logic channel_clear,
    input wire logic status_append_enable,
    // radio data register handshakes
    input wire logic rx_byte_arrive,
    input wire logic rx_byte_read,
    input wire logic rx_status1_read,
    input wire logic tx_byte_write,
    input wire logic tx_byte_need,
    // raw event status levels from the modem
    input wire radio_pkg::event_vec_t event_status,
    // cpu side flags and enables
    input wire logic data_transfer_flag_clr,
    input wire logic data_transfer_enable,
    input wire logic [7:0] radio_event_flags_wdata,
    input wire logic radio_event_flags_we,
    input wire logic [7:0] radio_event_mask,
    input wire logic radio_cpu_flag_clr,
    input wire logic radio_event_enable,
    // state and flags
    output logic [2:0] radio_state,
    output logic synth_on,
    output logic data_transfer_flag,
    output logic [7:0] radio_event_flags,
    output logic radio_cpu_flag,
    // interrupt requests, vector 0 and vector 16
    output logic data_transfer_irq,
    output logic radio_event_irq
);
    radio_pkg::radio_state_t state_q, state_d;
    radio_pkg::cal_target_t target_q, target_d;
    logic [15:0] timer_q, timer_d;
    logic rx_full_q, tx_armed_q, tx_room_q;
    logic [7:0] status_prev_q;
    logic dt_flag_q, cpu_flag_q;
    logic [7:0] ev_flags_q;
    logic dt_irq_q, ev_irq_q;

    wire auto_cal = auto_calibration_select == `AUTOCAL_FROM_IDLE;
    wire timer_done = timer_q == 16'h0000;
    wire is_synth_on = strobe.write && strobe.value == `STROBE_SYNTH_ON;
    wire is_cal = strobe.write && strobe.value == `STROBE_CALIBRATE;
    wire is_rx = strobe.write && strobe.value == `STROBE_RECEIVE;
    wire is_tx = strobe.write && strobe.value == `STROBE_TRANSMIT;
    wire is_idle = strobe.write && strobe.value == `STROBE_IDLE;
    // the synthesizer runs in every state that tunes or uses it
    wire synth_running = state_q == radio_pkg::ST_SYNTH || state_q == radio_pkg::ST_RX
        || state_q == radio_pkg::ST_TX || state_q == radio_pkg::ST_CAL;
    // rx overrun: a new byte lands while the previous one is unread
    wire rx_overrun = state_q == radio_pkg::ST_RX && rx_byte_arrive && rx_full_q && !rx_byte_read;
    // tx underrun: the modem wants a byte while the register is still empty
    wire tx_underrun = state_q == radio_pkg::ST_TX && tx_byte_need && tx_room_q && tx_armed_q;
    wire [7:0] ev_raw = event_status;
    wire [7:0] ev_rise_base = ev_raw & ~status_prev_q;
    // an overrun or underrun also counts as a finished packet
    wire err_done = rx_overrun || tx_underrun;
    wire [7:0] ev_err = ({7'h00, tx_underrun} << `EV_TX_UNDERFLOW)
        | ({7'h00, rx_overrun} << `EV_RX_OVERFLOW) | ({7'h00, err_done} << `EV_DONE);
    // limitation: a status already high at reset release reads as an edge
    wire [7:0] ev_hw = ev_rise_base | ev_err;
    // raised by the sequencer in the cycle that transmit is entered
    logic tx_arm_pulse;
    wire dt_rx_ready = state_q == radio_pkg::ST_RX && rx_byte_arrive;
    wire dt_tx_room = state_q == radio_pkg::ST_TX && tx_armed_q && !tx_room_q && tx_byte_need;
    wire dt_status2 = status_append_enable && rx_status1_read;
    wire dt_set = dt_rx_ready || dt_tx_room || dt_status2 || tx_arm_pulse;

    // strobe sequencer; while leaving for idle all strobes are dropped
    always_comb begin
        state_d = state_q;
        target_d = target_q;
        // the timer counts down to zero and rests there
        timer_d = timer_done ? timer_q : 16'(timer_q - 16'h0001);
        tx_arm_pulse = 1'b0;
        case (state_q)
            radio_pkg::ST_IDLE: begin
                if (is_synth_on) begin
                    state_d = auto_cal ? radio_pkg::ST_CAL : radio_pkg::ST_SYNTH;
                    target_d = radio_pkg::AFTER_SYNTH;
                    timer_d = 16'(CAL_CYCLES - 1);
                end else if (is_cal) begin
                    state_d = radio_pkg::ST_CAL;
                    target_d = radio_pkg::AFTER_IDLE;
                    timer_d = 16'(CAL_CYCLES - 1);
                end else if (is_rx) begin
                    state_d = auto_cal ? radio_pkg::ST_CAL : radio_pkg::ST_RX;
                    target_d = radio_pkg::AFTER_RX;
                    timer_d = 16'(CAL_CYCLES - 1);
                end else if (is_tx) begin
                    state_d = auto_cal ? radio_pkg::ST_CAL : radio_pkg::ST_TX;
                    target_d = radio_pkg::AFTER_TX;
                    timer_d = 16'(CAL_CYCLES - 1);
                    tx_arm_pulse = !auto_cal;
                end
            end
            radio_pkg::ST_CAL: begin
                if (is_idle) begin
                    state_d = radio_pkg::ST_LEAVE;
                    timer_d = 16'(SETTLE_CYCLES - 1);
                end else if (timer_done) begin
                    case (target_q)
                        radio_pkg::AFTER_SYNTH: state_d = radio_pkg::ST_SYNTH;
                        radio_pkg::AFTER_RX: state_d = radio_pkg::ST_RX;
                        radio_pkg::AFTER_TX: begin
                            state_d = radio_pkg::ST_TX;
                            tx_arm_pulse = 1'b1;
                        end
                        default: state_d = radio_pkg::ST_IDLE;
                    endcase
                end
            end
            radio_pkg::ST_SYNTH: begin
                if (is_idle) begin
                    state_d = radio_pkg::ST_LEAVE;
                    timer_d = 16'(SETTLE_CYCLES - 1);
                end else if (is_rx) begin
                    state_d = radio_pkg::ST_RX;
                end else if (is_tx) begin
                    state_d = radio_pkg::ST_TX;
                    tx_arm_pulse = 1'b1;
                end
            end
            radio_pkg::ST_RX: begin
                if (is_idle) begin
                    state_d = radio_pkg::ST_LEAVE;
                    timer_d = 16'(SETTLE_CYCLES - 1);
                end else if (rx_overrun) begin
                    state_d = radio_pkg::ST_RX_OVF;
                end else if (is_synth_on && cca_enable) begin
                    state_d = radio_pkg::ST_SYNTH;
                end else if (is_tx && (!cca_enable || channel_clear)) begin
                    state_d = radio_pkg::ST_TX;
                    tx_arm_pulse = 1'b1;
                end
            end
            radio_pkg::ST_TX: begin
                if (is_idle) begin
                    state_d = radio_pkg::ST_LEAVE;
                    timer_d = 16'(SETTLE_CYCLES - 1);
                end else if (tx_underrun) begin
                    state_d = radio_pkg::ST_TX_UNF;
                end
            end
            radio_pkg::ST_LEAVE: begin
                if (timer_done) begin
                    state_d = radio_pkg::ST_IDLE;
                end
            end
            // error states exit by idle only
            default: begin
                if (is_idle) begin
                    state_d = radio_pkg::ST_LEAVE;
                    timer_d = 16'(SETTLE_CYCLES - 1);
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= radio_pkg::ST_IDLE;
            target_q <= radio_pkg::AFTER_IDLE;
            timer_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            target_q <= target_d;
            timer_q <= timer_d;
        end
    end

    // data register occupancy tracking
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_full_q <= 1'b0;
            tx_armed_q <= 1'b0;
            tx_room_q <= 1'b0;
        end else begin
            // an arrival wins over a read in the same cycle
            if (rx_byte_arrive) begin
                rx_full_q <= 1'b1;
            end else if (rx_byte_read || rx_status1_read) begin
                rx_full_q <= 1'b0;
            end
            if (state_d != radio_pkg::ST_TX) begin
                tx_armed_q <= 1'b0;
                tx_room_q <= 1'b0;
            end else if (tx_arm_pulse) begin
                tx_armed_q <= 1'b1;
                tx_room_q <= 1'b1;
            end else if (tx_byte_write) begin
                tx_room_q <= 1'b0;
            end else if (tx_byte_need) begin
                tx_room_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_prev_q <= 8'h00;
        end else begin
            status_prev_q <= ev_raw;
        end
    end

    // data flag, set beats clear; status read sets if status_append_enable
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            dt_flag_q <= 1'b0;
        // a status read with status_append_enable set and a clear in one cycle keep the flag
        end else if (dt_set) begin
            dt_flag_q <= 1'b1;
        end else if (data_transfer_flag_clr) begin
            dt_flag_q <= 1'b0;
        end
    end

    // event flags, write 0 clears, set wins
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ev_flags_q <= `EVENT_FLAGS_RESET;
        end else if (radio_event_flags_we) begin
            // written ones keep a bit, written zeros clear it
            ev_flags_q <= (ev_flags_q & radio_event_flags_wdata) | ev_hw;
        end else begin
            ev_flags_q <= ev_flags_q | ev_hw;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cpu_flag_q <= 1'b0;
        // a clear in the cycle of a masked event loses to the event
        end else if (|(ev_hw & radio_event_mask)) begin
            cpu_flag_q <= 1'b1;
        end else if (radio_cpu_flag_clr) begin
            cpu_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            dt_irq_q <= 1'b0;
            ev_irq_q <= 1'b0;
        end else begin
            // requests trail their flags by one cycle
            dt_irq_q <= dt_flag_q && data_transfer_enable;
            ev_irq_q <= cpu_flag_q && radio_event_enable;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            radio_state <= 3'h0;
            synth_on <= 1'b0;
        end else begin
            radio_state <= state_q;
            synth_on <= synth_running;
        end
    end

    // flag outputs come straight from their flops
    assign data_transfer_flag = dt_flag_q;
    assign radio_event_flags = ev_flags_q;
    assign radio_cpu_flag = cpu_flag_q;
    assign data_transfer_irq = dt_irq_q;
    assign radio_event_irq = ev_irq_q;
endmodule

// ==== radio_strobe_and_interrupts_props.sv ====
// assertions on the radio strobe and interrupt block ports
`timescale 1ns/1ps
module radio_strobe_and_interrupts_props #(
    parameter int CAL_CYCLES = 100,
    parameter int SETTLE_CYCLES = 10
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // watched inputs
    input wire radio_pkg::strobe_req_t strobe,
    input wire logic [1:0] auto_calibration_select,
    input wire radio_pkg::event_vec_t event_status,
    input wire logic data_transfer_enable,
    input wire logic [7:0] radio_event_mask,
    input wire logic radio_event_enable,
    // watched outputs
    input wire logic [2:0] radio_state,
    input wire logic data_transfer_flag,
    input wire logic [7:0] radio_event_flags,
    input wire logic radio_cpu_flag,
    input wire logic data_transfer_irq,
    input wire logic radio_event_irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic wr_q;
    logic settled;
    logic go_rx;
    // shown idle with no strobe just taken means idle inside as well
    assign settled = radio_state == radio_pkg::ST_IDLE && !wr_q;
    assign go_rx = strobe.write && strobe.value == 8'h02;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b)
            wr_q <= 1'b0;
        else
            wr_q <= strobe.write;
    end
    property p_rx_direct;
        settled && go_rx && auto_calibration_select == 2'h0 |=> ##1 radio_state == 3'h3;
    endproperty
    a_rx_direct: assert property (p_rx_direct) else $error("receive not entered");
    property p_cal_first;
        settled && strobe.write && strobe.value inside {8'h00, 8'h02, 8'h03}
            && auto_calibration_select == 2'h1 |=> ##1 radio_state == 3'h1;
    endproperty
    a_cal_first: assert property (p_cal_first) else $error("no calibration");
    property p_idle_leave;
        radio_state == 3'h3 && !wr_q && strobe.write && strobe.value == 8'h04
            |=> ##1 radio_state == 3'h5;
    endproperty
    a_idle_leave: assert property (p_idle_leave) else $error("idle strobe lost");
    property p_leave_deaf;
        radio_state == 3'h5 |=> radio_state inside {3'h5, 3'h0};
    endproperty
    a_leave_deaf: assert property (p_leave_deaf) else $error("strobe taken while leaving");
    property p_ev_rise;
        $rose(event_status.carrier) |=> radio_event_flags[3];
    endproperty
    a_ev_rise: assert property (p_ev_rise) else $error("event edge not flagged");
    property p_cpu_flag;
        $rose(event_status.frame_start) && radio_event_mask[0] |=> radio_cpu_flag;
    endproperty
    a_cpu_flag: assert property (p_cpu_flag) else $error("cpu flag not set");
    property p_dt_irq;
        data_transfer_irq == $past(data_transfer_flag && data_transfer_enable);
    endproperty
    a_dt_irq: assert property (p_dt_irq) else $error("data request wrong");
    property p_ev_irq;
        radio_event_irq == $past(radio_cpu_flag && radio_event_enable);
    endproperty
    a_ev_irq: assert property (p_ev_irq) else $error("event request wrong");
    c_rx: cover property (radio_state == 3'h3);
    c_tx: cover property (radio_state == 3'h4);
    c_ovf: cover property (radio_state == 3'h6);
endmodule
bind radio_strobe_and_interrupts radio_strobe_and_interrupts_props #(
    .CAL_CYCLES(CAL_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES)) u_props (
    .ref_clk(ref_clk), .rst_b(rst_b), .strobe(strobe),
    .auto_calibration_select(auto_calibration_select), .event_status(event_status),
    .data_transfer_enable(data_transfer_enable), .radio_event_mask(radio_event_mask),
    .radio_event_enable(radio_event_enable), .radio_state(radio_state),
    .data_transfer_flag(data_transfer_flag), .radio_event_flags(radio_event_flags),
    .radio_cpu_flag(radio_cpu_flag), .data_transfer_irq(data_transfer_irq),
    .radio_event_irq(radio_event_irq));

// ==== cpu_model.sv ====
// cpu-side model: command writes, flag clears and data register reads
`timescale 1ns/1ps
module cpu_model (
    // clock
    input wire logic ref_clk,
    // command register write
    output radio_pkg::strobe_req_t strobe,
    // flag clears and data register accesses
    output logic data_transfer_flag_clr,
    output logic rx_byte_read,
    output logic rx_status1_read,
    output logic tx_byte_write,
    output logic radio_cpu_flag_clr,
    output logic radio_event_flags_we,
    output logic [7:0] radio_event_flags_wdata
);
    logic [5:0] act = 6'h00;
    assign {radio_event_flags_we, radio_cpu_flag_clr, tx_byte_write} = act[5:3];
    assign {rx_status1_read, rx_byte_read, data_transfer_flag_clr} = act[2:0];
    initial begin
        strobe = '0;
        radio_event_flags_wdata = 8'h00;
    end
    task automatic send_strobe(input logic [7:0] v);
        @(posedge ref_clk);
        #1 strobe = '{write: 1'b1, value: v};
        @(posedge ref_clk);
        // released value is scrambled so nothing leans on it
        #1 strobe = '{write: 1'b0, value: ~v};
    endtask
    task automatic pulse(input logic [5:0] m);
        @(posedge ref_clk);
        #1 act = m;
        @(posedge ref_clk);
        #1 act = 6'h00;
    endtask
    task automatic write_flags(input logic [7:0] d);
        radio_event_flags_wdata = d;
        pulse(6'h20);
    endtask
    task automatic read_status1();
        pulse(6'h01);
        pulse(6'h04);
    endtask
endmodule

// ==== tb_top.sv ====
// self-checking bench for the radio strobe and interrupt block
`timescale 1ns/1ps
module tb_top;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] autocal = 2'h0;
    logic cca_enable = 1'b0;
    logic channel_clear = 1'b0;
    logic append = 1'b0;
    logic rx_byte_arrive = 1'b0;
    logic tx_need = 1'b0;
    logic dt_en = 1'b0;
    logic [7:0] ev_mask = 8'h00;
    logic ev_en = 1'b0;
    radio_pkg::event_vec_t event_status = '0;
    radio_pkg::strobe_req_t strobe;
    logic dt_clr, rx_read, st1_read, tx_write, cpu_clr, ev_we;
    logic [7:0] ev_wdata;
    logic [2:0] radio_state;
    logic synth_on, dt_flag, cpu_flag, dt_irq, ev_irq;
    logic [7:0] ev_flags;
    logic [7:0] noop [3] = '{8'h05, 8'h80, 8'hff};
    int n_fail = 0;
    int comparisons = 0;
    radio_strobe_and_interrupts #(
        .CAL_CYCLES(2), .SETTLE_CYCLES(4)
    ) u_radio_strobe_and_interrupts (
        .ref_clk(ref_clk), .rst_b(rst_b), .strobe(strobe),
        .auto_calibration_select(autocal), .cca_enable(cca_enable),
        .channel_clear(channel_clear), .status_append_enable(append),
        .rx_byte_arrive(rx_byte_arrive), .rx_byte_read(rx_read), .rx_status1_read(st1_read),
        .tx_byte_write(tx_write), .tx_byte_need(tx_need), .event_status(event_status),
        .data_transfer_flag_clr(dt_clr), .data_transfer_enable(dt_en),
        .radio_event_flags_wdata(ev_wdata), .radio_event_flags_we(ev_we),
        .radio_event_mask(ev_mask), .radio_cpu_flag_clr(cpu_clr), .radio_event_enable(ev_en),
        .radio_state(radio_state), .synth_on(synth_on), .data_transfer_flag(dt_flag),
        .radio_event_flags(ev_flags), .radio_cpu_flag(cpu_flag),
        .data_transfer_irq(dt_irq), .radio_event_irq(ev_irq));
    cpu_model u_cpu_model (
        .ref_clk(ref_clk), .strobe(strobe), .data_transfer_flag_clr(dt_clr),
        .rx_byte_read(rx_read), .rx_status1_read(st1_read), .tx_byte_write(tx_write),
        .radio_cpu_flag_clr(cpu_clr), .radio_event_flags_we(ev_we),
        .radio_event_flags_wdata(ev_wdata));
    always #4 ref_clk = ~ref_clk;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (n_fail == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wait_state(input logic [2:0] s);
        int i;
        for (i = 0; i < 300 && radio_state !== s; i++) cyc(1);
        check(8'(radio_state), 8'(s));
        if (i == 300) print_verdict();
    endtask
    task automatic go(input logic [7:0] v, input logic [2:0] s);
        u_cpu_model.send_strobe(v);
        wait_state(s);
    endtask
    task automatic stay(input logic [7:0] v, input logic [2:0] s);
        u_cpu_model.send_strobe(v);
        cyc(3);
        check(8'(radio_state), 8'(s));
    endtask
    task automatic need();
        tx_need = 1'b1;
        cyc(1);
        tx_need = 1'b0;
    endtask
    task automatic arrive();
        rx_byte_arrive = 1'b1;
        cyc(1);
        rx_byte_arrive = 1'b0;
    endtask
    initial begin
        cyc(6);
        rst_b = 1'b1;
        check(ev_flags, 8'h00);
        foreach (noop[k]) stay(noop[k], radio_pkg::ST_IDLE);
        go(8'h01, radio_pkg::ST_CAL);
        wait_state(radio_pkg::ST_IDLE);
        check(8'(synth_on), 8'h00);
        go(8'h00, radio_pkg::ST_SYNTH);
        check(8'(synth_on), 8'h01);
        go(8'h02, radio_pkg::ST_RX);
        dt_en = 1'b1;
        arrive();
        check(8'(dt_flag), 8'h01);
        cyc(1);
        check(8'(dt_irq), 8'h01);
        u_cpu_model.pulse(6'h02);
        append = 1'b1;
        u_cpu_model.read_status1();
        check(8'(dt_flag), 8'h01);
        arrive();
        cyc(1);
        arrive();
        wait_state(radio_pkg::ST_RX_OVF);
        check(ev_flags, 8'h50);
        stay(8'h02, radio_pkg::ST_RX_OVF);
        go(8'h04, radio_pkg::ST_IDLE);
        u_cpu_model.write_flags(8'h00);
        check(ev_flags, 8'h00);
        u_cpu_model.pulse(6'h01);
        autocal = 2'h1;
        go(8'h03, radio_pkg::ST_CAL);
        check(8'(dt_flag), 8'h00);
        wait_state(radio_pkg::ST_TX);
        cyc(2);
        check(8'(dt_flag), 8'h01);
        go(8'h04, radio_pkg::ST_IDLE);
        autocal = 2'h0;
        go(8'h02, radio_pkg::ST_RX);
        cca_enable = 1'b1;
        stay(8'h03, radio_pkg::ST_RX);
        u_cpu_model.send_strobe(8'h04);
        u_cpu_model.send_strobe(8'h02);
        wait_state(radio_pkg::ST_IDLE);
        stay(8'h00, radio_pkg::ST_SYNTH);
        go(8'h02, radio_pkg::ST_RX);
        go(8'h00, radio_pkg::ST_SYNTH);
        go(8'h02, radio_pkg::ST_RX);
        channel_clear = 1'b1;
        go(8'h03, radio_pkg::ST_TX);
        u_cpu_model.pulse(6'h01);
        u_cpu_model.pulse(6'h08);
        check(8'(dt_flag), 8'h00);
        need();
        check(8'(dt_flag), 8'h01);
        need();
        wait_state(radio_pkg::ST_TX_UNF);
        check(ev_flags, 8'h90);
        stay(8'h03, radio_pkg::ST_TX_UNF);
        go(8'h04, radio_pkg::ST_IDLE);
        cyc(1);
        check(8'(synth_on), 8'h00);
        u_cpu_model.write_flags(8'h00);
        check(ev_flags, 8'h00);
        ev_mask = 8'h01;
        ev_en = 1'b1;
        for (int i = 0; i < 8; i++) begin
            event_status = radio_pkg::event_vec_t'(8'h01 << i);
            cyc(2);
            check(ev_flags, 8'h01 << i);
            check(8'(cpu_flag), 8'(i == 0));
            check(8'(ev_irq), 8'(i == 0));
            u_cpu_model.pulse(6'h10);
            u_cpu_model.write_flags(8'h00);
            cyc(2);
            check(ev_flags, 8'h00);
            event_status = '0;
        end
        print_verdict();
    end
endmodule
